// ===== shared/srw_regs.svh
`ifndef SRW_REGS_SVH
`define SRW_REGS_SVH

// Register addresses on the special-function-register bus
`define SRW_ADDR_RELOAD_HIGH 8'hA6
`define SRW_ADDR_KEY 8'hAE

// Reset values and key encoding
`define SRW_KEY_RESET 8'h55
`define SRW_RELOAD_RESET 8'h00
`define SRW_COUNT_RESET 24'h000000
`define SRW_LOW_CLEAR 16'h0000

// Machine cycle length in core clocks
`define SRW_MACH_CLKS 4

// Low-voltage release extension in ns and in cycles at 100 ns
`define SRW_LV_EXT_NS 1000
`define SRW_CLK_NS 100
`define SRW_LV_EXT_CYC ((`SRW_LV_EXT_NS + `SRW_CLK_NS - 1) / `SRW_CLK_NS)

// Program address taken after reset
`define SRW_RESET_VECTOR 16'h0000

`endif

// ===== shared/srw_pkg.sv
package srw_pkg;

    // Low-voltage extension state, Gray from SRW_LV_IDLE through SRW_LV_LOW to SRW_LV_EXT
    typedef enum logic [1:0] {
        SRW_LV_IDLE = 2'b00,
        SRW_LV_LOW = 2'b01,
        SRW_LV_EXT = 2'b11
    } srw_lv_state_t;

    // Whole block state
    typedef struct packed {
        logic sync1;
        logic sync2;
        srw_lv_state_t lv_st;
        logic [15:0] lv_cnt;
        logic [7:0] key;
        logic [23:0] count;
        logic [3:0] phase;
        logic power_up;
        logic wd_fire;
        logic core_rst;
    } srw_state_t;

endpackage

// ===== rtl/srw_supervisor.sv
`timescale 1ns/1ps
`include "srw_regs.svh"

module srw_supervisor #(
    parameter int MACH_CLKS = `SRW_MACH_CLKS,
    parameter int LV_EXT_CYC = `SRW_LV_EXT_CYC
) (
    input wire logic clk_i, // Core clock, 10 MHz
    input wire logic rst_n_i, // Power-on asynchronous reset
    input wire logic ext_reset_n_i, // External reset pin, low active
    input wire logic low_voltage_detector_i, // Supply below threshold
    input wire logic debug_reset_i, // Debug port reset command
    input wire logic idle_i, // Core in idle mode
    input wire logic power_down_i, // Core in power-down mode
    input wire logic stall_i, // Wait states or queue stall
    input wire logic sfr_wr_i, // Register write strobe
    input wire logic [7:0] sfr_addr_i, // Register address
    input wire logic [7:0] sfr_wdata_i, // Register write data
    input wire logic power_up_clr_i, // Firmware clears power-up flag
    output logic core_reset_o, // Core reset, high active
    output logic mem_reset_n_o, // Memory module reset, low active
    output logic [15:0] reset_vector_o, // Start address after reset
    output logic power_up_flag_o, // Cold-reset flag
    output logic watchdog_enabled_o, // Watchdog counting allowed
    output logic [23:0] watchdog_counter_o // Current watchdog count
);

    // Registered block state
    srw_pkg::srw_state_t s_q;

    // Next block state
    srw_pkg::srw_state_t s_d;

    // Synchronised pin request
    logic pin_rst;

    // Low-voltage request, live or extended
    logic lv_rst;

    // Debug port request
    logic dbg_rst;

    // Watchdog overflow request
    logic wd_rst;

    // Merged internal reset request
    logic any_rst;

    // Idle or power-down active
    logic low_power;

    // Key differs from the disable value
    logic wd_en;

    // Phase at end of machine cycle
    logic phase_last;

    // One machine cycle completes
    logic mach_tick;

    // Key register write
    logic wr_key;

    // Reload register write
    logic wr_reload;

    // Low voltage seen while tracker idle
    logic lv_enter;

    // Extension interval used up
    logic lv_ext_done;

    // Counter advances this cycle
    logic wd_step;

    // Counter plus one, with carry
    logic [24:0] inc;

    // Carry out of the top counter bit
    logic wd_carry;

    // Pin source after the two-stage synchroniser
    assign pin_rst = s_q.sync2;

    // Low-voltage source: live level acts at once, tracker holds it on
    assign lv_rst = low_voltage_detector_i
        | (s_q.lv_st != srw_pkg::SRW_LV_IDLE);

    // Debug source, not gated by any mode
    assign dbg_rst = debug_reset_i;

    // Watchdog source, one-cycle pulse
    assign wd_rst = s_q.wd_fire;

    // Reset merge of all four sources
    assign any_rst = pin_rst | lv_rst | dbg_rst | wd_rst;

    // Low-power modes freeze the watchdog
    assign low_power = idle_i | power_down_i;

    // Watchdog enable from the key
    assign wd_en = (s_q.key != `SRW_KEY_RESET);

    // Register write decode
    assign wr_key = sfr_wr_i & (sfr_addr_i == `SRW_ADDR_KEY);
    assign wr_reload = sfr_wr_i & (sfr_addr_i == `SRW_ADDR_RELOAD_HIGH);

    // Machine-cycle end; a stall stretches the cycle
    assign phase_last = (s_q.phase == 4'(MACH_CLKS - 1));
    assign mach_tick = phase_last & ~stall_i;

    // Low-voltage tracker helpers
    assign lv_enter = low_voltage_detector_i
        & (s_q.lv_st == srw_pkg::SRW_LV_IDLE);
    assign lv_ext_done = (s_q.lv_cnt == 16'(LV_EXT_CYC - 1));

    // Counting allowed: enabled, machine cycle done, no low power, no reload, no reset
    assign wd_step = wd_en & mach_tick & ~low_power & ~wr_reload
        & ~any_rst;

    // Increment with carry kept apart
    assign inc = {1'b0, s_q.count} + 25'h0000001;

    // Overflow is the carry out of bit 23
    assign wd_carry = inc[24];

    // Next-state logic
    always_comb begin
        s_d = s_q;

        // Pin synchroniser, two stages
        s_d.sync1 = ~ext_reset_n_i;
        s_d.sync2 = s_q.sync1;

        // Overflow pulse lasts one cycle
        s_d.wd_fire = 1'b0;

        // Registered reset for core and memory module
        s_d.core_rst = any_rst;

        // Low-voltage tracker, independent of any mode or register
        case (s_q.lv_st)
            srw_pkg::SRW_LV_IDLE: begin
                s_d.lv_cnt = 16'h0000;
                if (low_voltage_detector_i) begin
                    s_d.lv_st = srw_pkg::SRW_LV_LOW;
                end
            end

            srw_pkg::SRW_LV_LOW: begin
                s_d.lv_cnt = 16'h0000;
                if (!low_voltage_detector_i) begin
                    s_d.lv_st = srw_pkg::SRW_LV_EXT;
                end
            end

            srw_pkg::SRW_LV_EXT: begin
                if (low_voltage_detector_i) begin
                    s_d.lv_st = srw_pkg::SRW_LV_LOW;
                end else if (lv_ext_done) begin
                    s_d.lv_st = srw_pkg::SRW_LV_IDLE;
                end else begin
                    s_d.lv_cnt = s_q.lv_cnt + 16'h0001;
                end
            end

            default: begin
                s_d.lv_st = srw_pkg::SRW_LV_LOW;
            end
        endcase

        // Power-up flag: set wins over firmware clear
        if (lv_enter) begin
            s_d.power_up = 1'b1;
        end else if (power_up_clr_i) begin
            s_d.power_up = 1'b0;
        end

        // Machine-cycle phase, held in low power and during stalls
        if (any_rst) begin
            s_d.phase = 4'h0;
        end else if (low_power) begin
            s_d.phase = s_q.phase;
        end else if (mach_tick) begin
            s_d.phase = 4'h0;
        end else if (!stall_i) begin
            s_d.phase = s_q.phase + 4'h1;
        end else begin
            s_d.phase = s_q.phase;
        end

        // Key: reset and overflow reload the disable value
        if (any_rst) begin
            s_d.key = `SRW_KEY_RESET;
        end else if (wd_step && wd_carry) begin
            s_d.key = `SRW_KEY_RESET;
        end else if (wr_key) begin
            s_d.key = sfr_wdata_i;
        end

        // Counter: reload write wins over the increment
        if (any_rst) begin
            s_d.count = `SRW_COUNT_RESET;
        end else if (wr_reload) begin
            s_d.count = {sfr_wdata_i, `SRW_LOW_CLEAR};
        end else if (wd_step) begin
            s_d.count = inc[23:0];
            s_d.wd_fire = wd_carry;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.sync1 <= 1'b0;
            s_q.sync2 <= 1'b0;
            s_q.lv_st <= srw_pkg::SRW_LV_IDLE;
            s_q.lv_cnt <= 16'h0000;
            s_q.key <= `SRW_KEY_RESET;
            s_q.count <= `SRW_COUNT_RESET;
            s_q.phase <= 4'h0;
            s_q.power_up <= 1'b1;
            s_q.wd_fire <= 1'b0;
            s_q.core_rst <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs from registers; reset vector is a constant
    assign core_reset_o = s_q.core_rst;
    assign mem_reset_n_o = ~s_q.core_rst;
    assign reset_vector_o = `SRW_RESET_VECTOR;
    assign power_up_flag_o = s_q.power_up;
    assign watchdog_enabled_o = wd_en;
    assign watchdog_counter_o = s_q.count;

endmodule

// ===== verif/srw_fw.sv
`timescale 1ns/1ps
// Firmware side of the register bus
module srw_fw (
    input wire logic clk_i, // Core clock
    output logic wr_o, // Write strobe
    output logic [7:0] addr_o, // Register address
    output logic [7:0] data_o // Write data
);
    // Idle bus at time zero
    initial {wr_o, addr_o, data_o} = 17'h0;
    // One-cycle write, then scrambled lines
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i);
        wr_o <= 1'h1;
        addr_o <= a;
        data_o <= d;
        @(posedge clk_i);
        wr_o <= 1'h0;
        addr_o <= ~a;
        data_o <= ~d;
    endtask
endmodule

// ===== verif/srw_props.sv
`timescale 1ns/1ps
module srw_props (
    input wire logic clk_i, rst_n_i, ext_reset_n_i, low_voltage_detector_i, debug_reset_i,
    input wire logic idle_i, power_down_i, stall_i, sfr_wr_i, core_reset_o, mem_reset_n_o,
    input wire logic power_up_flag_o, watchdog_enabled_o,
    input wire logic [7:0] sfr_addr_i, sfr_wdata_i,
    input wire logic [15:0] reset_vector_o,
    input wire logic [23:0] watchdog_counter_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Release of reset after the pin
    sequence s_go;
        ##[1:4] !core_reset_o;
    endsequence
    // Checks
    a_mem_reset: assert property (mem_reset_n_o == !core_reset_o)
        else $error("bad memory reset");
    a_vector: assert property (reset_vector_o == 16'h0000)
        else $error("bad vector");
    a_debug_rst: assert property (debug_reset_i |=> core_reset_o)
        else $error("no debug reset");
    a_low_volt: assert property (low_voltage_detector_i |=> core_reset_o && power_up_flag_o)
        else $error("no low voltage reset");
    a_pin_reset: assert property (!ext_reset_n_i [*4] |-> core_reset_o)
        else $error("no pin reset");
    a_pin_end: assert property ($rose(ext_reset_n_i) && !low_voltage_detector_i |-> s_go)
        else $error("pin reset stretched");
    a_key_reset: assert property (core_reset_o |=> !watchdog_enabled_o &&
        watchdog_counter_o == 24'h000000) else $error("watchdog not reset");
    a_reload_wr: assert property (sfr_wr_i && sfr_addr_i == 8'hA6 && !core_reset_o &&
        !debug_reset_i |=> watchdog_counter_o == {$past(sfr_wdata_i), 16'h0000})
        else $error("bad reload");
    a_key_write: assert property (sfr_wr_i && sfr_addr_i == 8'hAE && !core_reset_o &&
        !debug_reset_i |=> watchdog_enabled_o == ($past(sfr_wdata_i) != 8'h55))
        else $error("bad key");
    a_freeze: assert property ((idle_i || power_down_i) && !sfr_wr_i && !debug_reset_i
        |=> $stable(watchdog_counter_o)) else $error("count moved in low power");
    a_count_rate: assert property ((watchdog_enabled_o && !stall_i && !idle_i &&
        !power_down_i && !sfr_wr_i && !core_reset_o) [*8] |->
        watchdog_counter_o - $past(watchdog_counter_o, 4) == 24'h000001)
        else $error("bad count rate");
endmodule
bind srw_supervisor srw_props p (.*);

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk_i = 1'h0, rst_n_i = 1'h0, ext_n = 1'h1, lv = 1'h0, dbg = 1'h0, clr = 1'h0;
    logic idle = 1'h0, pd = 1'h0, stl = 1'h0, wr, cr, mr, pf, en;
    logic [7:0] ad, wd;
    logic [15:0] vec;
    logic [23:0] cnt, c0, cw;
    logic rw, ew;
    logic [2:0] ph = 3'h0;
    int miscompares = 0, check_count = 0;
    logic [31:0] rows [3] = '{32'h04040000, 32'hFFFF0000, 32'h00000000};
    // Core clock
    always #50 clk_i = ~clk_i;
    srw_fw fw (.clk_i(clk_i), .wr_o(wr), .addr_o(ad), .data_o(wd));
    srw_supervisor #(.LV_EXT_CYC(3)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ext_reset_n_i(ext_n), .low_voltage_detector_i(lv), .debug_reset_i(dbg),
        .idle_i(idle), .power_down_i(pd), .stall_i(stl), .sfr_wr_i(wr),
        .sfr_addr_i(ad), .sfr_wdata_i(wd), .power_up_clr_i(clr), .core_reset_o(cr),
        .mem_reset_n_o(mr), .reset_vector_o(vec), .power_up_flag_o(pf),
        .watchdog_enabled_o(en), .watchdog_counter_o(cnt));
    // Fast-count copy for overflow, one machine cycle per clock; stalled one clock in eight
    always @(posedge clk_i) ph <= ph + 3'h1;
    srw_supervisor #(.MACH_CLKS(1), .LV_EXT_CYC(3)) dut_wd (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ext_reset_n_i(ext_n), .low_voltage_detector_i(lv), .debug_reset_i(dbg),
        .idle_i(idle), .power_down_i(pd), .stall_i(stl | (&ph)), .sfr_wr_i(wr),
        .sfr_addr_i(ad), .sfr_wdata_i(wd), .power_up_clr_i(clr), .core_reset_o(rw),
        .mem_reset_n_o(), .reset_vector_o(), .power_up_flag_o(),
        .watchdog_enabled_o(ew), .watchdog_counter_o(cw));
    task chk(input logic [23:0] s, e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, s, e);
        end
    endtask
    task stop_test;
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Main sequence
    initial begin
        cyc(1);
        #1 chk(cr, 1'h1);
        chk(mr, 1'h0);
        cyc(9);
        rst_n_i <= 1'h1;
        cyc(3);
        #1 chk(cr, 1'h0);
        chk(en, 1'h0);
        foreach (rows[i]) begin
            fw.wr(8'hA6, rows[i][31:24]);
            #1 chk(cnt, rows[i][23:0]);
        end
        fw.wr(8'hA5, 8'h00);
        #1 chk(en, 1'h0);
        fw.wr(8'hAE, 8'h00);
        #1 chk(en, 1'h1);
        c0 = cnt;
        cyc(8);
        #1 chk(cnt, c0 + 24'h000002);
        for (int k = 1; k < 8; k = k * 2) begin
            cyc(1);
            {pd, idle, stl} <= 3'(k);
            cyc(1);
            #1 c0 = cnt;
            cyc(8);
            #1 chk(cnt, c0);
        end
        cyc(1);
        dbg <= 1'h1;
        cyc(2);
        #1 chk(cr, 1'h1);
        chk(en, 1'h0);
        chk(cnt, 24'h000000);
        cyc(1);
        {dbg, pd, idle, stl} <= 4'h0;
        cyc(3);
        #1 chk(cr, 1'h0);
        cyc(1);
        clr <= 1'h1;
        cyc(1);
        clr <= 1'h0;
        #1 chk(pf, 1'h0);
        cyc(1);
        lv <= 1'h1;
        cyc(2);
        lv <= 1'h0;
        #1 chk(pf, 1'h1);
        cyc(3);
        #1 chk(cr, 1'h1);
        cyc(4);
        #1 chk(cr, 1'h0);
        chk(pf, 1'h1);
        cyc(1);
        ext_n <= 1'h0;
        cyc(4);
        ext_n <= 1'h1;
        #1 chk(cr, 1'h1);
        cyc(5);
        #1 chk(cr, 1'h0);
        fw.wr(8'hAE, 8'h12);
        #1 chk(en, 1'h1);
        fw.wr(8'hAE, 8'h55);
        #1 chk(en, 1'h0);
        fw.wr(8'hA6, 8'hFF);
        fw.wr(8'hAE, 8'h00);
        #1 chk(cw, 24'hFF0000);
        do begin
            cyc(1);
            #1;
        end while (cw !== 24'h000000);
        chk(ew, 1'h0);
        cyc(1);
        #1 chk(rw, 1'h1);
        cyc(1);
        #1 chk(rw, 1'h0);
        chk(cw, 24'h000000);
        stop_test;
    end
    // Hang guard
    initial begin
        #8000000;
        miscompares++;
        stop_test;
    end
endmodule
